// [rtl/mcrb_bank.sv]
// Purpose: Modem configuration and status registers behind AXI4-Lite
// Assumes: One clock, synchronous active-low reset
// Notes:   Carrier and ring pins pass a three-stage synchroniser
//
// Chosen here: the AXI4-Lite register port.
`include "mcrb_params.svh"

module mcrb_bank
  import mcrb_pkg::*;
#(
  parameter logic [31:0] CR_UNIT_CYC = 32'((`MCRB_CR_UNIT_NUM
    * `MCRB_CLK_KHZ + `MCRB_CR_UNIT_DEN - 1) / `MCRB_CR_UNIT_DEN),
  parameter logic [31:0] CW_UNIT_CYC =
    32'(`MCRB_CW_UNIT_S * `MCRB_CLK_KHZ * 1000),
  parameter logic [31:0] AT_UNIT_CYC =
    32'(`MCRB_AT_UNIT_US * (`MCRB_CLK_KHZ / 1000)),
  parameter logic [31:0] RING_GAP_CYC =
    32'(`MCRB_RING_GAP_MS * `MCRB_CLK_KHZ)
)
(
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [9:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [9:0]  s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  input  wire logic        carrier_pin_in,
  input  wire logic        ring_pin_in,
  input  wire logic        call_start_in,
  input  wire logic        off_hook_in,
  input  wire logic        answer_mode_in,
  input  wire logic [7:0]  line_volts_in,
  input  wire logic [7:0]  proc_status_in,
  output logic             carrier_valid_out,
  output logic             call_abort_out,
  output logic             answer_tone_out,
  output logic             ring_valid_out,
  output logic [15:0]      proc_addr_out,
  output logic [13:0]      proc_data_out,
  output logic [7:0]       proc_ctrl_low_out,
  output logic [7:0]       proc_ctrl_high_out
);

  // --------------------------------------------------------------------
  // Plain bit-mapped storage
  // --------------------------------------------------------------------
  localparam int NPLAIN = 9;
  localparam logic [7:0] PLAIN_IDX [NPLAIN] = '{
    `MCRB_IDX_CI_GAIN, `MCRB_IDX_RST_CTL, `MCRB_IDX_INTR_SET,
    `MCRB_IDX_DG_SET, `MCRB_IDX_CFG_ONE, `MCRB_IDX_PIO_A,
    `MCRB_IDX_PIO_B, `MCRB_IDX_PIN_DIR, `MCRB_IDX_CFG_FIVE};
  localparam logic [7:0] PLAIN_RST [NPLAIN] = '{
    `MCRB_RST_CI_GAIN, `MCRB_RST_RST_CTL, `MCRB_RST_INTR_SET,
    `MCRB_RST_DG_SET, `MCRB_RST_CFG_ONE, `MCRB_RST_PIO_A,
    `MCRB_RST_ZERO, `MCRB_RST_ZERO, `MCRB_RST_ZERO};

  logic [7:0]  plain_q [NPLAIN];
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  aw_idx_q, aw_idx_d, w_data_q, w_data_d;
  logic        w_strb_q, w_strb_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        do_wr, wr_en;
  logic [7:0]  ar_idx;
  logic [7:0]  cdr_q, cdr_d, cdt_q, cdt_d, atd_q, atd_d, rp_q, rp_d;
  logic [7:0]  mode_q, mode_d, lvs_q, lvs_d;
  logic [15:0] paddr_q, paddr_d;
  logic [13:0] pdata_q, pdata_d;
  logic [7:0]  pctl_lo_q, pctl_lo_d, pctl_hi_q, pctl_hi_d;

  assign do_wr  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en  = do_wr && w_strb_q;
  assign ar_idx = s_axi_araddr_in[9:2];

  for (genvar i = 0; i < NPLAIN; i++)
  begin : g_plain
    logic [7:0] val_d;
    always_comb
    begin
      val_d = plain_q[i];
      if (wr_en && aw_idx_q == PLAIN_IDX[i])
      begin
        val_d = w_data_q;
      end
    end
    always_ff @(posedge clk_sys_in)
    begin
      if (!resetn_in)
      begin
        plain_q[i] <= PLAIN_RST[i];
      end
      else
      begin
        plain_q[i] <= val_d;
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite slave and register writes
  // --------------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NPLAIN; i++)
    begin
      hit = hit || (idx == PLAIN_IDX[i]);
    end
    return hit || idx inside {`MCRB_IDX_CR_TIME, `MCRB_IDX_CW_TMO,
      `MCRB_IDX_AT_DLY, `MCRB_IDX_RING_CNT, `MCRB_IDX_LINE_V,
      `MCRB_IDX_WIN_LOW, `MCRB_IDX_WIN_HIGH, `MCRB_IDX_PA_MODE};
  endfunction : mapped

  always_comb
  begin
    aw_have_d = aw_have_q;
    aw_idx_d  = aw_idx_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    cdr_d     = cdr_q;
    cdt_d     = cdt_q;
    atd_d     = atd_q;
    rp_d      = rp_q;
    mode_d    = mode_q;
    paddr_d   = paddr_q;
    pdata_d   = pdata_q;
    pctl_lo_d = pctl_lo_q;
    pctl_hi_d = pctl_hi_q;
    if (s_axi_awvalid_in && awready_q)
    begin
      aw_have_d = 1'b1;
      aw_idx_d  = s_axi_awaddr_in[9:2];
    end
    if (s_axi_wvalid_in && wready_q)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata_in[7:0];
      w_strb_d = s_axi_wstrb_in[0];
    end
    if (bvalid_q && s_axi_bready_in)
    begin
      bvalid_d = 1'b0;
    end
    if (do_wr)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(aw_idx_q) ? MCRB_RESP_OKAY : MCRB_RESP_SLVERR;
    end
    if (wr_en)
    begin
      unique case (aw_idx_q)
        `MCRB_IDX_CR_TIME:  cdr_d  = w_data_q;
        `MCRB_IDX_CW_TMO:   cdt_d  = w_data_q;
        `MCRB_IDX_AT_DLY:   atd_d  = w_data_q;
        `MCRB_IDX_RING_CNT: rp_d   = w_data_q;
        `MCRB_IDX_PA_MODE:  mode_d = w_data_q;
        `MCRB_IDX_WIN_LOW:
        begin
          // Window meaning follows the mode already in place
          if (mode_q == MCRB_MODE_ADDR)
            paddr_d[7:0] = w_data_q;
          else if (mode_q == MCRB_MODE_DATA)
            pdata_d[7:0] = w_data_q;
          else if (mode_q == MCRB_MODE_CTRL)
            pctl_lo_d = w_data_q;
        end
        `MCRB_IDX_WIN_HIGH:
        begin
          if (mode_q == MCRB_MODE_ADDR)
            paddr_d[15:8] = w_data_q;
          else if (mode_q == MCRB_MODE_DATA)
            pdata_d[13:8] = w_data_q[5:0];
          else if (mode_q == MCRB_MODE_CTRL)
            pctl_hi_d = w_data_q;
        end
        default: ;
      endcase
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------
  always_comb
  begin
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rvalid_q && s_axi_rready_in)
    begin
      rvalid_d  = 1'b0;
    end
    if (s_axi_arvalid_in && arready_q)
    begin
      rvalid_d  = 1'b1;
      rresp_d   = mapped(ar_idx) ? MCRB_RESP_OKAY : MCRB_RESP_SLVERR;
      rdata_d   = 8'h00;
      for (int i = 0; i < NPLAIN; i++)
      begin
        if (ar_idx == PLAIN_IDX[i])
          rdata_d = plain_q[i];
      end
      unique case (ar_idx)
        `MCRB_IDX_CR_TIME:  rdata_d = cdr_q;
        `MCRB_IDX_CW_TMO:   rdata_d = cdt_q;
        `MCRB_IDX_AT_DLY:   rdata_d = atd_q;
        `MCRB_IDX_RING_CNT: rdata_d = rp_q;
        `MCRB_IDX_LINE_V:   rdata_d = lvs_q;
        `MCRB_IDX_PA_MODE:  rdata_d = mode_q;
        `MCRB_IDX_WIN_LOW:
          if (mode_q == MCRB_MODE_CTRL)
            rdata_d = proc_status_in;
        default: ;
      endcase
    end
    // Read address open whenever no read answer is pending
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 8'h00;
      rresp_q   <= 2'h0;
      cdr_q     <= `MCRB_RST_CR_TIME;
      cdt_q     <= `MCRB_RST_CW_TMO;
      atd_q     <= `MCRB_RST_AT_DLY;
      rp_q      <= `MCRB_RST_RING_CNT;
      mode_q    <= MCRB_MODE_ADDR;
      paddr_q   <= 16'h0000;
      pdata_q   <= 14'h0000;
      pctl_lo_q <= 8'h00;
      pctl_hi_q <= 8'h00;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      aw_idx_q  <= aw_idx_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      cdr_q     <= cdr_d;
      cdt_q     <= cdt_d;
      atd_q     <= atd_d;
      rp_q      <= rp_d;
      mode_q    <= mode_d;
      paddr_q   <= paddr_d;
      pdata_q   <= pdata_d;
      pctl_lo_q <= pctl_lo_d;
      pctl_hi_q <= pctl_hi_d;
    end
  end

  // --------------------------------------------------------------------
  // Line timers and voltage readout
  // --------------------------------------------------------------------
  logic [2:0]  car_s_q, ring_s_q;
  logic        car_lvl_q, car_lvl_d, ring_lvl_q, ring_lvl_d;
  logic        ring_prev_q;
  logic [31:0] cr_pre_q, cr_pre_d, cw_pre_q, cw_pre_d;
  logic [31:0] at_pre_q, at_pre_d, gap_q, gap_d;
  logic [7:0]  cr_cnt_q, cr_cnt_d, cw_cnt_q, cw_cnt_d;
  logic [7:0]  at_cnt_q, at_cnt_d, rg_cnt_q, rg_cnt_d;
  logic        car_ok_q, car_ok_d, wait_q, wait_d, abort_q, abort_d;
  logic        tone_q, tone_d, ring_ok_q, ring_ok_d;
  logic        answering;
  logic signed [7:0] volts;

  assign answering = off_hook_in && answer_mode_in;
  assign volts     = $signed(line_volts_in);

  always_comb
  begin
    car_lvl_d  = (car_s_q[1] == car_s_q[2]) ? car_s_q[2] : car_lvl_q;
    ring_lvl_d = (ring_s_q[1] == ring_s_q[2]) ? ring_s_q[2] : ring_lvl_q;
    cr_pre_d = cr_pre_q;
    cr_cnt_d = cr_cnt_q;
    car_ok_d = car_ok_q;
    if (!car_lvl_q)
    begin
      cr_pre_d = 32'h0;
      cr_cnt_d = 8'h00;
      car_ok_d = 1'b0;
    end
    else if (!car_ok_q)
    begin
      if (cr_cnt_q >= cdr_q)
        car_ok_d = 1'b1;
      else if (cr_pre_q == CR_UNIT_CYC - 32'h1)
      begin
        cr_pre_d = 32'h0;
        cr_cnt_d = cr_cnt_q + 8'h01;
      end
      else
        cr_pre_d = cr_pre_q + 32'h1;
    end
    cw_pre_d = cw_pre_q;
    cw_cnt_d = cw_cnt_q;
    wait_d   = wait_q;
    abort_d  = abort_q;
    if (call_start_in)
    begin
      wait_d   = 1'b1;
      abort_d  = 1'b0;
      cw_pre_d = 32'h0;
      cw_cnt_d = 8'h00;
    end
    else if (wait_q)
    begin
      if (car_ok_q)
        wait_d = 1'b0;
      else if (cw_cnt_q >= cdt_q)
      begin
        wait_d  = 1'b0;
        abort_d = 1'b1;
      end
      else if (cw_pre_q == CW_UNIT_CYC - 32'h1)
      begin
        cw_pre_d = 32'h0;
        cw_cnt_d = cw_cnt_q + 8'h01;
      end
      else
        cw_pre_d = cw_pre_q + 32'h1;
    end
    at_pre_d = at_pre_q;
    at_cnt_d = at_cnt_q;
    tone_d   = tone_q;
    if (!answering)
    begin
      at_pre_d = 32'h0;
      at_cnt_d = 8'h00;
      tone_d   = 1'b0;
    end
    else if (!tone_q)
    begin
      if (at_cnt_q >= atd_q)
        tone_d = 1'b1;
      else if (at_pre_q == AT_UNIT_CYC - 32'h1)
      begin
        at_pre_d = 32'h0;
        at_cnt_d = at_cnt_q + 8'h01;
      end
      else
        at_pre_d = at_pre_q + 32'h1;
    end
    gap_d    = gap_q;
    rg_cnt_d = rg_cnt_q;
    if (ring_lvl_q && !ring_prev_q)
    begin
      gap_d = 32'h0;
      if (rg_cnt_q != 8'hff)
        rg_cnt_d = rg_cnt_q + 8'h01;
    end
    else if (gap_q == RING_GAP_CYC - 32'h1)
      rg_cnt_d = 8'h00;
    else
      gap_d = gap_q + 32'h1;
    ring_ok_d = (rg_cnt_d != 8'h00) && (rg_cnt_d >= rp_q);
    if (volts >= 8'sd3 || volts <= -8'sd3)
      lvs_d = line_volts_in;
    else
      lvs_d = 8'h00;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      car_s_q     <= 3'h0;
      ring_s_q    <= 3'h0;
      car_lvl_q   <= 1'b0;
      ring_lvl_q  <= 1'b0;
      ring_prev_q <= 1'b0;
      cr_pre_q    <= 32'h0;
      cw_pre_q    <= 32'h0;
      at_pre_q    <= 32'h0;
      gap_q       <= 32'h0;
      cr_cnt_q    <= 8'h00;
      cw_cnt_q    <= 8'h00;
      at_cnt_q    <= 8'h00;
      rg_cnt_q    <= 8'h00;
      car_ok_q    <= 1'b0;
      wait_q      <= 1'b0;
      abort_q     <= 1'b0;
      tone_q      <= 1'b0;
      ring_ok_q   <= 1'b0;
      lvs_q       <= 8'h00;
    end
    else
    begin
      car_s_q     <= {car_s_q[1:0], carrier_pin_in};
      ring_s_q    <= {ring_s_q[1:0], ring_pin_in};
      car_lvl_q   <= car_lvl_d;
      ring_lvl_q  <= ring_lvl_d;
      ring_prev_q <= ring_lvl_q;
      cr_pre_q    <= cr_pre_d;
      cw_pre_q    <= cw_pre_d;
      at_pre_q    <= at_pre_d;
      gap_q       <= gap_d;
      cr_cnt_q    <= cr_cnt_d;
      cw_cnt_q    <= cw_cnt_d;
      at_cnt_q    <= at_cnt_d;
      rg_cnt_q    <= rg_cnt_d;
      car_ok_q    <= car_ok_d;
      wait_q      <= wait_d;
      abort_q     <= abort_d;
      tone_q      <= tone_d;
      ring_ok_q   <= ring_ok_d;
      lvs_q       <= lvs_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign s_axi_awready_out  = awready_q;
  assign s_axi_wready_out   = wready_q;
  assign s_axi_bvalid_out   = bvalid_q;
  assign s_axi_bresp_out    = bresp_q;
  assign s_axi_arready_out  = arready_q;
  assign s_axi_rvalid_out   = rvalid_q;
  assign s_axi_rdata_out    = {24'h000000, rdata_q};
  assign s_axi_rresp_out    = rresp_q;
  assign carrier_valid_out  = car_ok_q;
  assign call_abort_out     = abort_q;
  assign answer_tone_out    = tone_q;
  assign ring_valid_out     = ring_ok_q;
  assign proc_addr_out      = paddr_q;
  assign proc_data_out      = pdata_q;
  assign proc_ctrl_low_out  = pctl_lo_q;
  assign proc_ctrl_high_out = pctl_hi_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_car_drop: assert property (!car_lvl_q |=> !car_ok_q)
    else $error("carrier valid without carrier");
  a_car_time: assert property ($rose(car_ok_q) |->
    $past(cr_cnt_q) >= $past(cdr_q))
    else $error("carrier recognised early");
  a_abort_why: assert property ($rose(abort_q) |->
    $past(wait_q) && !$past(car_ok_q) &&
    $past(cw_cnt_q) >= $past(cdt_q))
    else $error("abort without timeout");
  a_tone_time: assert property ($rose(tone_q) |->
    $past(answering) && $past(at_cnt_q) >= $past(atd_q))
    else $error("answer tone early");
  a_ring_min: assert property (ring_ok_q |->
    rg_cnt_q >= rp_q && rg_cnt_q != 8'h00)
    else $error("ring burst too short");
  a_lvs_pass: assert property ((volts >= 8'sd3) |=>
    lvs_q == $past(line_volts_in))
    else $error("line voltage not reported");
  a_lvs_zero: assert property ((volts < 8'sd3 && volts > -8'sd3)
    |=> lvs_q == 8'h00)
    else $error("small line voltage not zero");
  a_addr_load: assert property (wr_en && mode_q == MCRB_MODE_ADDR &&
    aw_idx_q == `MCRB_IDX_WIN_HIGH |=>
    paddr_q[15:8] == $past(w_data_q))
    else $error("address high byte not loaded");
  a_data_high: assert property (wr_en && mode_q == MCRB_MODE_DATA &&
    aw_idx_q == `MCRB_IDX_WIN_HIGH |=>
    pdata_q[13:8] == $past(w_data_q[5:0]) && $stable(paddr_q))
    else $error("data high bits not loaded");
  a_status_rd: assert property (s_axi_arvalid_in && arready_q &&
    ar_idx == `MCRB_IDX_WIN_LOW && mode_q == MCRB_MODE_CTRL |=>
    rvalid_q && rdata_q == $past(proc_status_in))
    else $error("status view wrong");
  a_mode_hold: assert property (mode_q != $past(mode_q) |->
    $past(wr_en) && $past(aw_idx_q) == `MCRB_IDX_PA_MODE)
    else $error("mode changed without write");

  c_carrier: cover property ($rose(car_ok_q));
  c_abort:   cover property ($rose(abort_q));
  c_tone:    cover property ($rose(tone_q));
  c_ring:    cover property ($rose(ring_ok_q));

endmodule : mcrb_bank

// [rtl/mcrb_params.svh]
// Purpose: Offsets, reset values and timing figures of the register bank
// Assumes: 40 MHz system clock
// Notes:   Offsets are register indexes; byte address is four times index
`ifndef MCRB_PARAMS_SVH
`define MCRB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define MCRB_IDX_CR_TIME   8'h37
`define MCRB_IDX_CW_TMO    8'h39
`define MCRB_IDX_AT_DLY    8'h3a
`define MCRB_IDX_RING_CNT  8'h3b
`define MCRB_IDX_CI_GAIN   8'h3c
`define MCRB_IDX_RST_CTL   8'h62
`define MCRB_IDX_INTR_SET  8'h82
`define MCRB_IDX_LINE_V    8'hdb
`define MCRB_IDX_DG_SET    8'hdf
`define MCRB_IDX_CFG_ONE   8'he0
`define MCRB_IDX_PIO_A     8'he1
`define MCRB_IDX_PIO_B     8'he2
`define MCRB_IDX_PIN_DIR   8'he3
`define MCRB_IDX_CFG_FIVE  8'he4
`define MCRB_IDX_WIN_LOW   8'he5
`define MCRB_IDX_WIN_HIGH  8'he6
`define MCRB_IDX_PA_MODE   8'he8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MCRB_RST_CR_TIME   8'h20
`define MCRB_RST_CW_TMO    8'h3c
`define MCRB_RST_AT_DLY    8'h29
`define MCRB_RST_RING_CNT  8'h03
`define MCRB_RST_CI_GAIN   8'h01
`define MCRB_RST_RST_CTL   8'h41
`define MCRB_RST_INTR_SET  8'h08
`define MCRB_RST_DG_SET    8'h0c
`define MCRB_RST_CFG_ONE   8'h22
`define MCRB_RST_PIO_A     8'h04
`define MCRB_RST_ZERO      8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MCRB_CLK_KHZ       40000
`define MCRB_CR_UNIT_NUM   5
`define MCRB_CR_UNIT_DEN   3
`define MCRB_CW_UNIT_S     1
`define MCRB_AT_UNIT_US    53330
`define MCRB_RING_GAP_MS   200
`define MCRB_LV_MIN_V      3

`endif

// [rtl/mcrb_pkg.sv]
// Purpose: Types shared by the register bank
// Assumes: Nothing
// Notes:   None
package mcrb_pkg;

  typedef enum logic [7:0]
  {
    MCRB_MODE_ADDR = 8'h00,
    MCRB_MODE_DATA = 8'h01,
    MCRB_MODE_CTRL = 8'h02
  } mcrb_mode_type;

  typedef enum logic [1:0]
  {
    MCRB_RESP_OKAY   = 2'h0,
    MCRB_RESP_SLVERR = 2'h2
  } mcrb_resp_type;

endpackage : mcrb_pkg

// [tb/mcrb_host_model.sv]
// Purpose: AXI4-Lite host model that drives the register bank
// Assumes: One write and one read under way at most
// Notes:   Released address and data lines show inverted values
module mcrb_host_model
  import mcrb_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        awready_in,
  input  wire logic        wready_in,
  input  wire logic        bvalid_in,
  input  wire logic        arready_in,
  input  wire logic        rvalid_in,
  output logic             awvalid_out,
  output logic [9:0]       awaddr_out,
  output logic             wvalid_out,
  output logic [31:0]      wdata_out,
  output logic [3:0]       wstrb_out,
  output logic             bready_out,
  output logic             arvalid_out,
  output logic [9:0]       araddr_out,
  output logic             rready_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    {awaddr_out, araddr_out, wdata_out, wstrb_out} = 56'h0;
  end

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] st);
    @(posedge clk_sys_in);
    awvalid_out <= 1'b1;
    wvalid_out  <= 1'b1;
    awaddr_out  <= {idx, 2'b00};
    wdata_out   <= {24'h000000, d};
    wstrb_out   <= st;
    bready_out  <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (awvalid_out && awready_in)
      begin
        awvalid_out <= 1'b0;
        awaddr_out  <= ~awaddr_out;
      end
      if (wvalid_out && wready_in)
      begin
        wvalid_out <= 1'b0;
        wdata_out  <= ~wdata_out;
      end
    end
    while (!bvalid_in);
    bready_out <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge clk_sys_in);
    arvalid_out <= 1'b1;
    araddr_out  <= {idx, 2'b00};
    rready_out  <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (arvalid_out && arready_in)
      begin
        arvalid_out <= 1'b0;
        araddr_out  <= ~araddr_out;
      end
    end
    while (!rvalid_in);
    rready_out <= 1'b0;
  endtask : rd
endmodule : mcrb_host_model

// [tb/test_modem_config_register_bank.sv]
// Purpose: Self-checking bench of the register bank
// Assumes: Short unit counts set through parameters
// Notes:   Read and write answers checked against queued notes
module test_modem_config_register_bank;
  import mcrb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in, resetn_in, s_axi_awvalid_in, s_axi_wvalid_in;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in, carrier_pin_in;
  logic ring_pin_in, call_start_in, off_hook_in, answer_mode_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, carrier_valid_out;
  logic call_abort_out, answer_tone_out, ring_valid_out;
  logic [9:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [7:0]  line_volts_in, proc_status_in, proc_ctrl_low_out;
  logic [7:0]  proc_ctrl_high_out, ra, rb;
  logic [15:0] proc_addr_out;
  logic [13:0] proc_data_out;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          fails = 0, n_compared = 0, cyc = 0, n;
  localparam logic [7:0] RI [15] = '{8'h37, 8'h39, 8'h3a, 8'h3b, 8'h3c,
    8'h62, 8'h82, 8'hdf, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he8, 8'hdb};
  localparam logic [7:0] RV [15] = '{8'h20, 8'h3c, 8'h29, 8'h03, 8'h01,
    8'h41, 8'h08, 8'h0c, 8'h22, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] VT [7] = '{8'h00, 8'h02, 8'hfe, 8'h03, 8'hfd,
    8'h80, 8'h7f};

  mcrb_bank #(.CR_UNIT_CYC(32'h4), .CW_UNIT_CYC(32'h8), .AT_UNIT_CYC(32'h6),
    .RING_GAP_CYC(32'h14)) mcrb_bank_inst (.clk_sys_in, .resetn_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out,
    .s_axi_rresp_out, .carrier_pin_in, .ring_pin_in, .call_start_in,
    .off_hook_in, .answer_mode_in, .line_volts_in, .proc_status_in,
    .carrier_valid_out, .call_abort_out, .answer_tone_out, .ring_valid_out,
    .proc_addr_out, .proc_data_out, .proc_ctrl_low_out, .proc_ctrl_high_out);
  mcrb_host_model mcrb_host_model_inst (.clk_sys_in,
    .awready_in(s_axi_awready_out), .wready_in(s_axi_wready_out),
    .bvalid_in(s_axi_bvalid_out), .arready_in(s_axi_arready_out),
    .rvalid_in(s_axi_rvalid_out), .awvalid_out(s_axi_awvalid_in),
    .awaddr_out(s_axi_awaddr_in), .wvalid_out(s_axi_wvalid_in),
    .wdata_out(s_axi_wdata_in), .wstrb_out(s_axi_wstrb_in),
    .bready_out(s_axi_bready_in), .arvalid_out(s_axi_arvalid_in),
    .araddr_out(s_axi_araddr_in), .rready_out(s_axi_rready_in));

  task automatic miss(input string m);
    fails++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : miss
  task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) miss($sformatf("read %h, wanted %h", got, exp));
  endtask : chk_rd
  task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) miss($sformatf("write answer %h, wanted %h", got, exp));
  endtask : chk_b
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) miss($sformatf("port %h, wanted %h", got, exp));
  endtask : chk_v
  task automatic wreg(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] r = MCRB_RESP_OKAY,
                      input logic [3:0] s = 4'h1);
    bq.push_back(r);
    mcrb_host_model_inst.wr(i, d, s);
  endtask : wreg
  task automatic rreg(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] r = MCRB_RESP_OKAY);
    rq.push_back({r, 24'h000000, d});
    mcrb_host_model_inst.rd(i);
  endtask : rreg
  // Cycles until the chosen output reaches the wanted level
  task automatic meas(input int sel, input logic lvl, input int lo, hi);
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (n < 200 && (sel == 0 ? carrier_valid_out : sel == 1 ?
      call_abort_out : sel == 2 ? answer_tone_out : ring_valid_out) !== lvl);
    chk_v(16'(n >= lo && n <= hi), 16'h0001);
  endtask : meas
  task automatic ring_pulse;
    ring_pin_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    ring_pin_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : ring_pulse
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (s_axi_rvalid_out && s_axi_rready_in)
      chk_rd({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
    if (s_axi_bvalid_out && s_axi_bready_in)
      chk_b(s_axi_bresp_out, bq.pop_front());
    if (cyc == 8000)
    begin
      miss("time limit reached");
      close_out();
    end
  end

  initial
  begin
    {resetn_in, carrier_pin_in, ring_pin_in, call_start_in} = 4'h0;
    {off_hook_in, answer_mode_in, line_volts_in, proc_status_in} = 18'h0;
    void'($urandom(33698));
    repeat (5) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 15; i++) rreg(RI[i], RV[i]);
    ra = 8'($urandom());
    wreg(8'h37, ra);
    rreg(8'h37, ra);
    wreg(8'h39, ~ra, MCRB_RESP_OKAY, 4'h0);
    rreg(8'h39, 8'h3c);
    wreg(8'h38, ra, MCRB_RESP_SLVERR);
    rreg(8'h38, 8'h00, MCRB_RESP_SLVERR);
    wreg(8'hdb, 8'h55);
    rreg(8'hdb, 8'h00);
    $display("test access done");
    for (int i = 0; i < 8; i++)
    begin
      ra = (i < 7) ? VT[i] : 8'($urandom());
      line_volts_in <= ra;
      rreg(8'hdb, ($signed(ra) > -3 && $signed(ra) < 3) ? 8'h00 : ra);
    end
    $display("test line voltage done");
    ra = 8'($urandom());
    rb = 8'($urandom());
    wreg(8'he8, 8'h00);
    wreg(8'he5, ra);
    wreg(8'he6, rb);
    @(posedge clk_sys_in);
    chk_v(proc_addr_out, {rb, ra});
    rreg(8'he5, 8'h00);
    wreg(8'he8, 8'h01);
    wreg(8'he5, rb);
    wreg(8'he6, ra | 8'hc0);
    @(posedge clk_sys_in);
    chk_v({2'b00, proc_data_out}, {2'b00, ra[5:0], rb});
    chk_v(proc_addr_out, {rb, ra});
    proc_status_in <= ra;
    wreg(8'he8, 8'h02);
    wreg(8'he5, ra);
    wreg(8'he6, rb);
    rreg(8'he5, ra);
    chk_v({proc_ctrl_high_out, proc_ctrl_low_out}, {rb, ra});
    wreg(8'he8, 8'h03);
    wreg(8'he5, ~ra);
    rreg(8'he8, 8'h03);
    chk_v({proc_ctrl_high_out, proc_ctrl_low_out}, {rb, ra});
    $display("test window done");
    wreg(8'h37, 8'h02);
    wreg(8'h39, 8'h03);
    wreg(8'h3a, 8'h02);
    wreg(8'h3b, 8'h03);
    carrier_pin_in <= 1'b1;
    meas(0, 1'b1, 9, 16);
    carrier_pin_in <= 1'b0;
    meas(0, 1'b0, 1, 8);
    call_start_in <= 1'b1;
    @(posedge clk_sys_in);
    call_start_in <= 1'b0;
    meas(1, 1'b1, 21, 31);
    {off_hook_in, answer_mode_in} <= 2'b11;
    meas(2, 1'b1, 10, 18);
    repeat (2) ring_pulse();
    repeat (4) @(posedge clk_sys_in);
    chk_v({15'h0, ring_valid_out}, 16'h0000);
    ring_pulse();
    meas(3, 1'b1, 1, 10);
    $display("test timers done");
    repeat (3) @(posedge clk_sys_in);
    close_out();
  end
endmodule : test_modem_config_register_bank
